/* File: core/thm_monitor.sv */
`timescale 1ns/1ps
// Two-hand, mat and mode-selector input evaluation.
module thm_monitor
  import thm_pkg::*;
#(
  parameter int TICK_CYCLES_P = thm_pkg::TICK_CYCLES,
  parameter int SYNC_WINDOW_MS_P = thm_pkg::SYNC_WINDOW_MS
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Two-hand station.
  input wire thm_pkg::thm_type_t two_hand_type_in,
  input wire thm_pkg::thm_buttons_t buttons_in,
  output logic two_hand_valid_out,
  output logic two_hand_sync_fail_out,
  // Safety mat channels, high while released.
  input wire thm_pkg::thm_mat_cfg_t mat_cfg_in,
  input wire logic [1:0] mat_chan_in,
  output logic mat_release_out,
  output logic mat_seq_error_out,
  // Mode selector.
  input wire logic mode_tested_in,
  input wire logic [3:0] mode_count_in,
  input wire logic [thm_pkg::MODE_MAX-1:0] mode_in,
  input wire logic [thm_pkg::MODE_MAX-1:0] mode_pulse_odd_in,
  output logic [thm_pkg::MODE_MAX-1:0] mode_sel_out,
  output logic mode_valid_out,
  output logic mode_cfg_error_out
);
  import thm_pkg::*;

  localparam int IN_W = 6 + MODE_MAX;
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES_P - 1);
  localparam logic [MS_CNT_W-1:0] WIN_MS = MS_CNT_W'(SYNC_WINDOW_MS_P);

  logic [IN_W-1:0] pins_sync;
  logic [3:0] btn;
  logic [1:0] mat;
  logic [MODE_MAX-1:0] mode;

  thm_sync2 #(.WIDTH(IN_W)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in({buttons_in, mat_chan_in, mode_in}),
    .sync_out(pins_sync)
  );
  assign btn = pins_sync[IN_W-1 -: 4];
  assign mat = pins_sync[MODE_MAX +: 2];
  assign mode = pins_sync[MODE_MAX-1:0];

  // Millisecond tick divider.
  logic [TICK_CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  always_comb begin
    tick = (tick_cnt_reg == TICK_LAST);
    tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // Per-hand on and off decoding.
  logic left_on, right_on, left_off, right_off;
  always_comb begin
    if (two_hand_type_in == THM_DUAL_NC) begin
      left_on = btn[3];
      right_on = btn[1];
      left_off = !btn[3];
      right_off = !btn[1];
    end else begin
      left_on = btn[3] && !btn[2];
      right_on = btn[1] && !btn[0];
      left_off = !btn[3] && btn[2];
      right_off = !btn[1] && btn[0];
    end
  end

  // Two-hand state machine with millisecond window.
  thm_state_t th_state_reg, th_state_next;
  logic [MS_CNT_W-1:0] win_reg, win_next;
  logic fail_reg, fail_next;
  always_comb begin
    th_state_next = th_state_reg;
    win_next = win_reg;
    fail_next = 1'b0;
    case (th_state_reg)
      THM_WAIT_OFF: begin
        if (left_off && right_off) begin
          th_state_next = THM_IDLE;
        end
      end
      THM_IDLE: begin
        win_next = '0;
        if (left_on && right_on) begin
          th_state_next = THM_ACTIVE;
        end else if (left_on || right_on) begin
          th_state_next = THM_ARMED;
        end
      end
      THM_ARMED: begin
        if (left_on && right_on) begin
          th_state_next = THM_ACTIVE;
        end else if (!left_on && !right_on) begin
          th_state_next = THM_WAIT_OFF;
        end else if (win_reg >= WIN_MS) begin
          th_state_next = THM_LOCKED;
          fail_next = 1'b1;
        end else if (tick) begin
          win_next = win_reg + 1'b1;
        end
      end
      THM_ACTIVE: begin
        if (!left_on || !right_on) begin
          th_state_next = THM_WAIT_OFF;
        end
      end
      THM_LOCKED: begin
        if (left_off && right_off) begin
          th_state_next = THM_IDLE;
        end
      end
      default: begin
        th_state_next = THM_WAIT_OFF;
      end
    endcase
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      th_state_reg <= THM_WAIT_OFF;
      win_reg <= '0;
      fail_reg <= 1'b0;
    end else begin
      th_state_reg <= th_state_next;
      win_reg <= win_next;
      fail_reg <= fail_next;
    end
  end
  assign two_hand_valid_out = (th_state_reg == THM_ACTIVE);
  assign two_hand_sync_fail_out = fail_reg;

  // Period code to milliseconds.
  function automatic logic [MS_CNT_W-1:0] per_ms(input logic [2:0] code);
    case (code)
      PER_40: per_ms = 11'h028;
      PER_200: per_ms = 11'h0c8;
      PER_400: per_ms = 11'h190;
      PER_600: per_ms = 11'h258;
      PER_800: per_ms = 11'h320;
      default: per_ms = 11'h3e8;
    endcase
  endfunction

  // Response time table; legacy uses the older shorter figures.
  logic [2:0] per_lo, per_hi;
  logic [MS_CNT_W-1:0] resp_ms, min_act_ms;
  always_comb begin
    per_lo = (mat_cfg_in.per_one < mat_cfg_in.per_two) ? mat_cfg_in.per_one
                                                       : mat_cfg_in.per_two;
    per_hi = (mat_cfg_in.per_one < mat_cfg_in.per_two) ? mat_cfg_in.per_two
                                                       : mat_cfg_in.per_one;
    min_act_ms = MS_CNT_W'({per_ms(per_hi), 1'b0});
    if (!mat_cfg_in.legacy) begin
      if (per_lo == per_hi) begin
        resp_ms = per_ms(per_hi);
      end else if (per_lo == PER_40) begin
        resp_ms = 11'h050;
      end else if (per_lo == PER_200) begin
        resp_ms = 11'h190;
      end else begin
        resp_ms = per_ms(per_hi);
      end
    end else begin
      if (per_lo == per_hi) begin
        resp_ms = (per_lo == PER_40) ? 11'h014 : per_ms(per_hi) - 11'h064;
      end else if (per_lo == PER_40) begin
        resp_ms = 11'h028;
      end else if (per_lo == PER_200) begin
        resp_ms = 11'h0c8;
      end else begin
        resp_ms = per_ms(per_lo);
      end
    end
  end

  // Mat: actuation when either channel drops; release delayed by response time.
  logic [MS_CNT_W:0] act_ms_reg, act_ms_next;
  logic [MS_CNT_W-1:0] rel_ms_reg, rel_ms_next;
  logic mat_rel_reg, mat_rel_next;
  logic seq_reg, seq_next;
  logic actuated;
  always_comb begin
    actuated = !(mat[0] && mat[1]);
    act_ms_next = act_ms_reg;
    rel_ms_next = rel_ms_reg;
    mat_rel_next = mat_rel_reg;
    seq_next = seq_reg;
    if (actuated) begin
      mat_rel_next = 1'b0;
      rel_ms_next = '0;
      if (tick && !act_ms_reg[MS_CNT_W]) begin
        act_ms_next = act_ms_reg + 1'b1;
      end
    end else begin
      if (act_ms_reg != '0 && act_ms_reg < {1'b0, min_act_ms}) begin
        seq_next = 1'b1;
      end
      act_ms_next = '0;
      if (seq_reg) begin
        mat_rel_next = 1'b0;
      end else if (rel_ms_reg >= resp_ms) begin
        mat_rel_next = 1'b1;
      end else if (tick) begin
        rel_ms_next = rel_ms_reg + 1'b1;
      end
    end
    // A sequencing error clears once a full-length actuation is seen.
    if (seq_reg && actuated && act_ms_reg >= {1'b0, min_act_ms}) begin
      seq_next = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      act_ms_reg <= '0;
      rel_ms_reg <= '0;
      mat_rel_reg <= 1'b0;
      seq_reg <= 1'b0;
    end else begin
      act_ms_reg <= act_ms_next;
      rel_ms_reg <= rel_ms_next;
      mat_rel_reg <= mat_rel_next;
      seq_reg <= seq_next;
    end
  end
  assign mat_release_out = mat_rel_reg;
  assign mat_seq_error_out = seq_reg;

  // Mode selector: exactly one contact of the configured ones closed.
  logic [MODE_MAX-1:0] mode_sel_next, mode_sel_reg, cfg_mask;
  logic mode_valid_next, mode_valid_reg, cfg_err_next, cfg_err_reg;
  logic [3:0] ones;
  always_comb begin
    cfg_mask = '0;
    ones = '0;
    cfg_err_next = 1'b0;
    if (mode_count_in < MODE_MIN_CNT || mode_count_in > MODE_MAX_UNTESTED ||
        (mode_tested_in && mode_count_in > MODE_MAX_TESTED)) begin
      cfg_err_next = 1'b1;
    end
    for (int i = 0; i < MODE_MAX; i++) begin
      if (4'(i) < mode_count_in) begin
        cfg_mask[i] = 1'b1;
        if (mode_tested_in && (mode_pulse_odd_in[i] != !i[0])) begin
          cfg_err_next = 1'b1;
        end
      end
      ones = ones + {3'h0, mode[i] & cfg_mask[i]};
    end
    mode_valid_next = !cfg_err_next && (ones == 4'h1) && ((mode & ~cfg_mask) == '0);
    mode_sel_next = mode_valid_next ? mode : '0;
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_sel_reg <= '0;
      mode_valid_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
    end else begin
      mode_sel_reg <= mode_sel_next;
      mode_valid_reg <= mode_valid_next;
      cfg_err_reg <= cfg_err_next;
    end
  end
  assign mode_sel_out = mode_sel_reg;
  assign mode_valid_out = mode_valid_reg;
  assign mode_cfg_error_out = cfg_err_reg;
endmodule : thm_monitor

/* File: inc/thm_pkg.sv */
// Notes on behaviour
// - Dual-NC type: valid only once both inputs were low and then both rose within 0.5 s.
// - Pair type: NC high/NO low is on, NC low/NO high off; valid needs off then on in 0.5 s.
// - Mat inputs add a response time set by the test period pair (current or legacy table).
// - The longer, current response times are used unless the legacy table is selected.
// - The mode selector supports 2 to 8 exclusive modes untested and 2 to 4 modes when tested.
package thm_pkg;
  // Timing figures in their own units.
  localparam int SYS_CLK_HZ = 40000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (SYS_CLK_HZ / 1000000) * TICK_US;
  localparam int SYNC_WINDOW_MS = 500;
  localparam int TICK_CNT_W = 16;
  localparam int MS_CNT_W = 11;
  // Test period codes: 40, 200, 400, 600, 800, 1000 ms.
  localparam logic [2:0] PER_40 = 3'h0;
  localparam logic [2:0] PER_200 = 3'h1;
  localparam logic [2:0] PER_400 = 3'h2;
  localparam logic [2:0] PER_600 = 3'h3;
  localparam logic [2:0] PER_800 = 3'h4;
  localparam logic [2:0] PER_1000 = 3'h5;
  // Mode selector limits.
  localparam int MODE_MAX = 8;
  localparam logic [3:0] MODE_MIN_CNT = 4'h2;
  localparam logic [3:0] MODE_MAX_UNTESTED = 4'h8;
  localparam logic [3:0] MODE_MAX_TESTED = 4'h4;

  typedef enum logic {
    THM_DUAL_NC,
    THM_NC_NO_PAIR
  } thm_type_t;

  typedef enum {
    THM_WAIT_OFF,
    THM_IDLE,
    THM_ARMED,
    THM_ACTIVE,
    THM_LOCKED
  } thm_state_t;

  // Raw contact levels of one two-hand station.
  typedef struct packed {
    logic left_nc;
    logic left_no;
    logic right_nc;
    logic right_no;
  } thm_buttons_t;

  // Mat configuration: periods of both pulse outputs and table choice.
  typedef struct packed {
    logic [2:0] per_one;
    logic [2:0] per_two;
    logic legacy;
  } thm_mat_cfg_t;
endpackage : thm_pkg

/* File: core/thm_sync2.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a bank of pin inputs.
module thm_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Data.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : thm_sync2

/* File: tb/thm_monitor_sva.sv */
`timescale 1ns/1ps
// Port-level checks on the input monitor.
module thm_monitor_sva
  import thm_pkg::*;
#(
  parameter int TICK_CYCLES_P = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire thm_pkg::thm_type_t two_hand_type_in,
  input wire thm_pkg::thm_buttons_t buttons_in,
  input wire logic two_hand_valid_out,
  input wire logic two_hand_sync_fail_out,
  input wire logic [1:0] mat_chan_in,
  input wire logic mat_release_out,
  input wire logic mode_tested_in,
  input wire logic [3:0] mode_count_in,
  input wire logic [thm_pkg::MODE_MAX-1:0] mode_sel_out,
  input wire logic mode_valid_out,
  input wire logic mode_cfg_error_out
);
  logic both_on;
  logic [15:0] free_cnt_reg;
  logic [15:0] free_cnt_next;
  // The pair type needs NC high and NO low on each hand to count as on.
  assign both_on = (two_hand_type_in == THM_DUAL_NC) ?
      (buttons_in.left_nc & buttons_in.right_nc) :
      (buttons_in.left_nc & ~buttons_in.left_no & buttons_in.right_nc & ~buttons_in.right_no);
  // Cycles the mat has stood free; saturates so a long idle never wraps.
  always_comb begin
    free_cnt_next = free_cnt_reg;
    if (!(&mat_chan_in)) free_cnt_next = 16'h0;
    else if (free_cnt_reg != 16'hffff) free_cnt_next = free_cnt_reg + 16'h1;
  end
  // Register of the free-mat count.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) free_cnt_reg <= 16'h0;
    else free_cnt_reg <= free_cnt_next;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  valid_rise_a: assert property ($rose(two_hand_valid_out) |-> $past(both_on, 3))
    else $error("two-hand valid rose without both hands on");
  valid_fall_a: assert property ($fell(two_hand_valid_out) |-> !$past(both_on, 3))
    else $error("two-hand valid dropped while both hands on");
  fail_lock_a: assert property (two_hand_sync_fail_out |=> !two_hand_valid_out [*4])
    else $error("two-hand valid soon after a window failure");
  mat_drop_a: assert property (!(&mat_chan_in) |-> ##[1:4] !mat_release_out)
    else $error("mat release stayed high during actuation");
  mat_wait_a: assert property (
      $rose(mat_release_out) |-> free_cnt_reg >= 19 * TICK_CYCLES_P)
    else $error("mat release came before the response time");
  mode_cnt_a: assert property ((mode_count_in < 4'h2 || mode_count_in > 4'h8 ||
      (mode_tested_in && mode_count_in > 4'h4)) |=> mode_cfg_error_out)
    else $error("illegal mode count not flagged");
  mode_one_a: assert property (
      mode_valid_out |-> $onehot(mode_sel_out) && !mode_cfg_error_out)
    else $error("mode valid without exactly one mode");
endmodule : thm_monitor_sva

bind thm_monitor thm_monitor_sva #(.TICK_CYCLES_P(TICK_CYCLES_P)) sva (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .two_hand_type_in(two_hand_type_in),
  .buttons_in(buttons_in), .two_hand_valid_out(two_hand_valid_out),
  .two_hand_sync_fail_out(two_hand_sync_fail_out), .mat_chan_in(mat_chan_in),
  .mat_release_out(mat_release_out), .mode_tested_in(mode_tested_in),
  .mode_count_in(mode_count_in), .mode_sel_out(mode_sel_out),
  .mode_valid_out(mode_valid_out), .mode_cfg_error_out(mode_cfg_error_out));

/* File: tb/thm_contacts.sv */
`timescale 1ns/1ps
// Passive contacts: two-hand buttons, one mat and the selector.
module thm_contacts
  import thm_pkg::*;
(
  // Positions: 0 off, 1 on, 2 broken with both contacts open.
  input wire logic [1:0] left_pos_in,
  input wire logic [1:0] right_pos_in,
  input wire logic mat_press_in,
  input wire logic [7:0] mode_knob_in,
  // Pin levels.
  output thm_pkg::thm_buttons_t buttons_out,
  output logic [1:0] mat_chan_out,
  output logic [7:0] mode_out
);
  always_comb begin
    buttons_out.left_nc = (left_pos_in == 2'h1);
    buttons_out.left_no = (left_pos_in == 2'h0);
    buttons_out.right_nc = (right_pos_in == 2'h1);
    buttons_out.right_no = (right_pos_in == 2'h0);
  end
  // A pressed mat shorts both channels low at once.
  assign mat_chan_out = mat_press_in ? 2'h0 : 2'h3;
  assign mode_out = mode_knob_in;
endmodule : thm_contacts

/* File: tb/two_hand_and_mat_input_monitor_tb_top.sv */
`timescale 1ns/1ps
module two_hand_and_mat_input_monitor_tb_top;
  import thm_pkg::*;
  localparam int TC = 4;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  thm_type_t hand_type = THM_DUAL_NC;
  thm_buttons_t buttons;
  thm_mat_cfg_t mat_cfg = 7'h0;
  logic [1:0] left_pos = 2'h0, right_pos = 2'h0, mat_chan;
  logic mat_press = 1'b0, mode_tested = 1'b0, fail_seen = 1'b0;
  logic [3:0] mode_count = 4'h8;
  logic [7:0] mode_knob = 8'h0, mode_odd = 8'h55, mode_sel, mode_pins;
  logic valid, fail, mat_rel, mat_err, mode_valid, mode_err;
  int error_cnt = 0, cmp_count = 0;

  // Free-running system clock.
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  thm_contacts partner (.left_pos_in(left_pos), .right_pos_in(right_pos),
    .mat_press_in(mat_press), .mode_knob_in(mode_knob), .buttons_out(buttons),
    .mat_chan_out(mat_chan), .mode_out(mode_pins));

  // Short tick and window keep the run brief; figures below derive from them.
  thm_monitor #(.TICK_CYCLES_P(TC), .SYNC_WINDOW_MS_P(5)) dut (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .two_hand_type_in(hand_type), .buttons_in(buttons),
    .two_hand_valid_out(valid), .two_hand_sync_fail_out(fail), .mat_cfg_in(mat_cfg),
    .mat_chan_in(mat_chan), .mat_release_out(mat_rel), .mat_seq_error_out(mat_err),
    .mode_tested_in(mode_tested), .mode_count_in(mode_count), .mode_in(mode_pins),
    .mode_pulse_odd_in(mode_odd), .mode_sel_out(mode_sel), .mode_valid_out(mode_valid),
    .mode_cfg_error_out(mode_err));

  // The failure flag is a one-cycle pulse, so it is latched here.
  always @(posedge clk_sys_in) begin
    if (fail === 1'b1) fail_seen <= 1'b1;
  end

  // Steps whole cycles, landing just after the edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : step

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Prints the counts and the verdict.
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Dual NC: one hand alone is not enough, both within the window are.
  task automatic t_dual();
    hand_type = THM_DUAL_NC;
    step(6);
    left_pos = 2'h1;
    step(4);
    chk("dual one hand", 8'h0, {7'h0, valid});
    right_pos = 2'h1;
    step(4);
    chk("dual both", 8'h1, {7'h0, valid});
    left_pos = 2'h0;
    step(4);
    chk("dual release", 8'h0, {7'h0, valid});
    right_pos = 2'h0;
  endtask : t_dual

  // Pair type: a broken contact counts as neither state.
  task automatic t_pair();
    hand_type = THM_NC_NO_PAIR;
    step(6);
    left_pos = 2'h1;
    right_pos = 2'h2;
    step(4);
    chk("pair broken", 8'h0, {7'h0, valid});
    right_pos = 2'h1;
    step(4);
    chk("pair both", 8'h1, {7'h0, valid});
    left_pos = 2'h0;
    right_pos = 2'h0;
    hand_type = THM_DUAL_NC;
  endtask : t_pair

  // Late second hand: failure, then locked until both hands are off.
  task automatic t_late();
    step(6);
    fail_seen = 1'b0;
    left_pos = 2'h1;
    step(30);
    right_pos = 2'h1;
    step(4);
    chk("late fail", 8'h1, {7'h0, fail_seen});
    chk("late valid", 8'h0, {7'h0, valid});
    right_pos = 2'h0;
    step(4);
    right_pos = 2'h1;
    step(4);
    chk("lock valid", 8'h0, {7'h0, valid});
    left_pos = 2'h0;
    right_pos = 2'h0;
    step(6);
    left_pos = 2'h1;
    right_pos = 2'h1;
    step(4);
    chk("relock valid", 8'h1, {7'h0, valid});
    left_pos = 2'h0;
    right_pos = 2'h0;
  endtask : t_late

  // One actuation held for hold_ms; release must wait resp_ms.
  task automatic mat_case(input thm_mat_cfg_t cfg, input int hold_ms, input int resp_ms);
    mat_cfg = cfg;
    mat_press = 1'b1;
    step(hold_ms * TC);
    chk("mat pressed", 8'h0, {7'h0, mat_rel});
    chk("mat err clear", 8'h0, {7'h0, mat_err});
    mat_press = 1'b0;
    step((resp_ms - 2) * TC);
    chk("mat early", 8'h0, {7'h0, mat_rel});
    step(4 * TC);
    chk("mat free", 8'h1, {7'h0, mat_rel});
  endtask : mat_case

  // Short actuation is flagged; full ones follow both response tables.
  task automatic t_mats();
    mat_cfg = {PER_40, PER_40, 1'b0};
    step(60 * TC);
    mat_press = 1'b1;
    step(20 * TC);
    mat_press = 1'b0;
    step(60 * TC);
    chk("mat seq err", 8'h1, {7'h0, mat_err});
    chk("mat held", 8'h0, {7'h0, mat_rel});
    mat_case({PER_40, PER_40, 1'b0}, 100, 40);
    mat_case({PER_40, PER_40, 1'b1}, 100, 20);
    mat_case({PER_40, PER_200, 1'b0}, 420, 80);
    mat_case({PER_200, PER_400, 1'b1}, 820, 200);
  endtask : t_mats

  // Applies one selector setting and compares the answer.
  task automatic mode_case(input logic t, input logic [3:0] n, input logic [7:0] odd,
      input logic [7:0] knob, input logic ok, input logic err);
    mode_tested = t;
    mode_count = n;
    mode_odd = odd;
    mode_knob = knob;
    step(4);
    chk("mode valid", {7'h0, ok}, {7'h0, mode_valid});
    chk("mode err", {7'h0, err}, {7'h0, mode_err});
    chk("mode sel", ok ? knob : 8'h0, mode_sel);
  endtask : mode_case

  // Selector counts, exclusivity and parity of tested contacts.
  task automatic t_mode();
    mode_case(1'b0, 4'h8, 8'h55, 8'h80, 1'b1, 1'b0);
    mode_case(1'b0, 4'h8, 8'h55, 8'h81, 1'b0, 1'b0);
    mode_case(1'b0, 4'h1, 8'h55, 8'h01, 1'b0, 1'b1);
    mode_case(1'b1, 4'h8, 8'h55, 8'h01, 1'b0, 1'b1);
    mode_case(1'b1, 4'h4, 8'h55, 8'h08, 1'b1, 1'b0);
    mode_case(1'b1, 4'h4, 8'h54, 8'h01, 1'b0, 1'b1);
  endtask : t_mode

  // Main sequence after twelve cycles of reset.
  initial begin
    step(12);
    rst_b_in = 1'b1;
    t_dual();
    t_pair();
    t_late();
    t_mats();
    t_mode();
    end_sim();
  end

  // Watchdog against a hang.
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    error_cnt++;
    end_sim();
  end
endmodule : two_hand_and_mat_input_monitor_tb_top
